// File: rtl/flash_event_interrupt_pkg.sv
// Constants for the flash event interrupt unit: register offsets,
// field positions, reset values and bus widths.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package flash_event_interrupt_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADR_W = 4;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int REG_W = 16;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_CONFIG   = 4'h0;
  localparam logic [ADR_W-1:0] OFS_STATUS   = 4'h4;
  localparam logic [ADR_W-1:0] OFS_SYS_STAT = 4'h8;
  localparam logic [ADR_W-1:0] OFS_SYS_MASK = 4'hC;

  // ==========================================================
  // Field positions
  localparam int BIT_OUT_DIS = 15;
  localparam int BIT_READY   = 4;
  localparam int BIT_POR     = 2;
  localparam int BIT_ECC2    = 1;
  localparam int BIT_ECC1    = 0;

  // ==========================================================
  // Field groups
  localparam logic [REG_W-1:0] EVENT_MASK  = 16'h0013;
  localparam logic [REG_W-1:0] CFG_WR_MASK = 16'h8013;
  localparam logic [REG_W-1:0] ST_W1C_MASK = 16'h0017;
  localparam logic [REG_W-1:0] SYS_MASK    = 16'h0017;

  // ==========================================================
  // Reset values
  localparam logic [REG_W-1:0] CONFIG_RST     = 16'hFFFF;
  localparam logic [REG_W-1:0] STATUS_POR_RST = 16'hFFFB;
  localparam logic [REG_W-1:0] STATUS_HW_RST  = 16'hFFFF;
  localparam logic [REG_W-1:0] SYS_STAT_RST   = 16'h0000;
  localparam logic [REG_W-1:0] SYS_MASK_RST   = 16'h0000;

endpackage

// File: rtl/flash_event_interrupt.sv
// Event interrupt unit of a serial NOR flash: configuration and status
// registers, open-drain interrupt pin, Wishbone register slave.
// Assumes busy and ECC inputs come from logic on clk_i; the hardware
// reset pin is asynchronous; an external pull-up holds the pin high.
//
// Function
// - The pin is open-drain: released when idle, pulled low for an event.
// - Config bit 4 at 0 makes a busy-to-ready transition a source.
// - Config bit 1 at 0 makes a 2-bit ECC error a source.
// - Config bit 0 at 0 makes a 1-bit ECC error a source.
// - Config bit 15 at 1 keeps the pin released whatever happens.
// - Status records each enabled event until cleared by software or reset.
// - With the output enabled an enabled event pulls the pin low.
// - Writing 1 to config bit 15 releases the pin and clears all status.
// - Writing 1 to an event enable bit clears its matching status bit.
// - Writing 1 to a status bit returns it to its no-event value 1.
// - With config bit 15 at 0 the pin stays low while any enabled status bit still shows 0.
// - Power-on or pin reset restores config defaults and frees the pin.
// - Status bit 4 reads 0 after a busy-to-ready transition, else 1.
// - Status bit 2 is 0 after power-on reset and 1 after pin reset.
// - Status bits 1 and 0 read 0 after a 2-bit or 1-bit ECC error.
// - Reserved bits of both registers read as 1 after either reset.
`timescale 1ns/1ps

module flash_event_interrupt
  import flash_event_interrupt_pkg::*;
(
  input  wire logic                                       clk_i,
  input  wire logic                                       rst_i,
  input  wire logic                                       hw_reset_n_i,
  input  wire logic                                       busy_i,
  input  wire logic                                       ecc2_err_i,
  input  wire logic                                       ecc1_err_i,
  input  wire logic                                       wb_cyc_i,
  input  wire logic                                       wb_stb_i,
  input  wire logic                                       wb_we_i,
  input  wire logic [flash_event_interrupt_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [flash_event_interrupt_pkg::SEL_W-1:0] wb_sel_i,
  input  wire logic [flash_event_interrupt_pkg::DAT_W-1:0] wb_dat_i,
  output logic      [flash_event_interrupt_pkg::DAT_W-1:0] wb_dat_o,
  output logic                                            wb_ack_o,
  output logic                                            int_n_o,
  output logic                                            int_oe_n_o,
  output logic                                            irq_o
);
  import flash_event_interrupt_pkg::*;

  // ==========================================================
  // Declarations
  logic [2:0]       hw_sync_q;
  logic             hw_rst_q;
  logic             busy_q;
  logic             wb_ack_q;
  logic [DAT_W-1:0] wb_dat_q;
  logic [REG_W-1:0] config_q;
  logic [REG_W-1:0] config_d;
  logic [REG_W-1:0] status_q;
  logic [REG_W-1:0] status_d;
  logic [REG_W-1:0] sys_stat_q;
  logic [REG_W-1:0] sys_stat_d;
  logic [REG_W-1:0] sys_mask_q;
  logic             int_oe_n_q;
  logic             int_n_q;
  logic             irq_q;
  logic             drive_d;
  logic             req;
  logic             wr_cfg;
  logic             wr_st;
  logic             wr_sstat;
  logic             wr_smask;
  logic [REG_W-1:0] lane_m;
  logic [REG_W-1:0] wdat;
  logic [REG_W-1:0] event_v;
  logic [REG_W-1:0] st_clr;
  logic [REG_W-1:0] st_set;
  logic [REG_W-1:0] sys_ev;

  // ==========================================================
  // Reset pin synchroniser and filter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hw_sync_q <= 3'h7;
    end else begin
      hw_sync_q <= {hw_sync_q[1:0], hw_reset_n_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hw_rst_q <= 1'b0;
    end else if (hw_sync_q[1] == hw_sync_q[2]) begin
      hw_rst_q <= ~hw_sync_q[2];
    end
  end

  // ==========================================================
  // Event detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_i;
    end
  end

  always_comb begin
    event_v             = '0;
    event_v[BIT_READY]  = busy_q & ~busy_i;
    event_v[BIT_ECC2]   = ecc2_err_i;
    event_v[BIT_ECC1]   = ecc1_err_i;
  end

  // ==========================================================
  // Wishbone decode
  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  assign wr_cfg   = req & wb_we_i & (wb_adr_i == OFS_CONFIG);
  assign wr_st    = req & wb_we_i & (wb_adr_i == OFS_STATUS);
  assign wr_sstat = req & wb_we_i & (wb_adr_i == OFS_SYS_STAT);
  assign wr_smask = req & wb_we_i & (wb_adr_i == OFS_SYS_MASK);
  assign lane_m   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdat     = wb_dat_i[REG_W-1:0] & lane_m;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
    end else begin
      wb_ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_q <= '0;
    end else if (req & ~wb_we_i) begin
      case (wb_adr_i)
        OFS_CONFIG:   wb_dat_q <= {16'h0000, config_q};
        OFS_STATUS:   wb_dat_q <= {16'h0000, status_q};
        OFS_SYS_STAT: wb_dat_q <= {16'h0000, sys_stat_q};
        OFS_SYS_MASK: wb_dat_q <= {16'h0000, sys_mask_q};
        default:      wb_dat_q <= '0;
      endcase
    end
  end

  // ==========================================================
  // Configuration register
  always_comb begin
    config_d = config_q;
    if (wr_cfg) begin
      config_d = (config_q & ~(CFG_WR_MASK & lane_m))
               | (wdat & CFG_WR_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hw_rst_q) begin
      config_q <= CONFIG_RST;
    end else begin
      config_q <= config_d;
    end
  end

  // ==========================================================
  // Status register
  always_comb begin
    st_clr = '0;
    if (wr_cfg && wdat[BIT_OUT_DIS]) begin
      st_clr = '1;
    end
    if (wr_cfg) begin
      st_clr = st_clr | (wdat & EVENT_MASK);
    end
    if (wr_st) begin
      st_clr = st_clr | (wdat & ST_W1C_MASK);
    end
    st_set   = event_v & ~config_q & EVENT_MASK;
    status_d = ((status_q | st_clr) & ~st_set) | ~ST_W1C_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= STATUS_POR_RST;
    end else if (hw_rst_q) begin
      status_q <= STATUS_HW_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // ==========================================================
  // Interrupt pin
  assign drive_d = ~config_q[BIT_OUT_DIS]
                 & |(~status_q & ~config_q & EVENT_MASK);

  always_ff @(posedge clk_i) begin
    if (rst_i || hw_rst_q) begin
      int_oe_n_q <= 1'b1;
    end else begin
      int_oe_n_q <= ~drive_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_n_q <= 1'b0;
    end else begin
      int_n_q <= 1'b0;
    end
  end

  // ==========================================================
  // System interrupt status and mask
  always_comb begin
    sys_ev          = event_v;
    sys_ev[BIT_POR] = int_oe_n_q & drive_d;
    sys_stat_d      = sys_stat_q;
    if (wr_sstat) begin
      sys_stat_d = sys_stat_q & ~wdat;
    end
    sys_stat_d = (sys_stat_d | sys_ev) & SYS_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_stat_q <= SYS_STAT_RST;
    end else begin
      sys_stat_q <= sys_stat_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_mask_q <= SYS_MASK_RST;
    end else if (wr_smask) begin
      sys_mask_q <= ((sys_mask_q & ~lane_m) | wdat) & SYS_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(sys_stat_d & sys_mask_q);
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o   = wb_ack_q;
  assign wb_dat_o   = wb_dat_q;
  assign int_n_o    = int_n_q;
  assign int_oe_n_o = int_oe_n_q;
  assign irq_o      = irq_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || hw_rst_q);

  sequence s_cfg_disable;
    wr_cfg && wdat[BIT_OUT_DIS];
  endsequence

  sequence s_released;
    int_oe_n_o ##1 int_oe_n_o;
  endsequence

  sequence s_ready_edge;
    busy_q && !busy_i && !config_q[BIT_READY];
  endsequence

  sequence s_ecc1_armed;
    ecc1_err_i && !config_q[BIT_ECC1] && !config_q[BIT_OUT_DIS] && !wr_cfg;
  endsequence

  a_pin_follows_state: assert property (
    drive_d |=> !int_oe_n_o)
    else $error("pin not driven for pending enabled event");

  a_pin_release_all: assert property (
    !drive_d |=> int_oe_n_o)
    else $error("pin driven with no pending enabled event");

  a_out_disable_hold: assert property (
    config_q[BIT_OUT_DIS] |=> int_oe_n_o)
    else $error("pin driven while output disabled");

  a_cfg15_clears: assert property (
    s_cfg_disable |=> config_q[BIT_OUT_DIS] ##1 s_released)
    else $error("output disable did not release pin");

  a_cfg15_status: assert property (
    s_cfg_disable and !(|event_v) |=> status_q == 16'hFFFF)
    else $error("output disable did not clear status");

  a_chan_clear: assert property (
    wr_cfg && wdat[BIT_ECC1] && !ecc1_err_i |=> status_q[BIT_ECC1])
    else $error("channel disable did not clear status bit");

  a_w1c_status: assert property (
    wr_st && wdat[BIT_ECC2] && !ecc2_err_i |=> status_q[BIT_ECC2])
    else $error("write one did not clear status bit");

  a_ready_record: assert property (
    s_ready_edge |=> !status_q[BIT_READY] ##1 !int_oe_n_o ||
                     config_q[BIT_OUT_DIS])
    else $error("ready transition not recorded");

  a_ecc2_record: assert property (
    ecc2_err_i && !config_q[BIT_ECC2] |=> !status_q[BIT_ECC2])
    else $error("2-bit error not recorded");

  a_ecc1_masked: assert property (
    config_q[BIT_ECC1] && status_q[BIT_ECC1] |=> status_q[BIT_ECC1])
    else $error("disabled 1-bit channel recorded an event");

  a_record_hold: assert property (
    !status_q[BIT_ECC1] && !wr_cfg && !wr_st |=> !status_q[BIT_ECC1])
    else $error("recorded event lost without clear");

  a_reserved_ones: assert property (
    (status_q | ST_W1C_MASK) == 16'hFFFF &&
    (config_q | CFG_WR_MASK) == 16'hFFFF)
    else $error("reserved bit not one");

  a_por_default: assert property (
    @(posedge clk_i) disable iff (1'b0)
    $fell(rst_i) && !hw_rst_q |-> !status_q[BIT_POR])
    else $error("power-on bit not set after power-on reset");

  a_reset_release: assert property (
    @(posedge clk_i) disable iff (1'b0)
    hw_rst_q |=> int_oe_n_o && config_q == 16'hFFFF)
    else $error("pin reset did not restore defaults");

  a_hw_status: assert property (
    @(posedge clk_i) disable iff (rst_i)
    hw_rst_q |=> status_q == 16'hFFFF)
    else $error("pin reset did not restore status");

  a_por_sticky: assert property (
    status_q[BIT_POR] |=> status_q[BIT_POR])
    else $error("power-on bit fell outside reset");

  a_ecc1_record: assert property (
    ecc1_err_i && !config_q[BIT_ECC1] |=> !status_q[BIT_ECC1])
    else $error("1-bit error not recorded");

  a_ecc2_masked: assert property (
    config_q[BIT_ECC2] && status_q[BIT_ECC2] |=> status_q[BIT_ECC2])
    else $error("disabled 2-bit channel recorded an event");

  a_ecc1_pin_low: assert property (
    s_ecc1_armed |=> !status_q[BIT_ECC1] ##1 !int_oe_n_o)
    else $error("enabled 1-bit error did not pull pin low");

  a_pin_level: assert property (
    int_n_o == 1'b0)
    else $error("pin value not low");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  a_read_upper: assert property (
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");

  a_irq_masked: assert property (
    sys_mask_q == 16'h0000 |=> !irq_o)
    else $error("system interrupt with all sources masked");

endmodule // flash_event_interrupt

// File: bench/int_pin_host.sv
// Host side model of the open-drain interrupt pin and its pull-up.
// Assumes the device pulls the pin only while its enable is low.
`timescale 1ns/1ps

// ==========================================================
// Pin resolution
module int_pin_host (
  input  wire logic int_n_i,
  input  wire logic int_oe_n_i,
  output logic      pin_o
);
  // External pull-up wins whenever the device lets go
  assign pin_o = int_oe_n_i ? 1'b1 : int_n_i;
endmodule // int_pin_host

// File: bench/tb_flash_event_interrupt.sv
// Self-checking bench for the flash event interrupt unit.
// Assumes the package constants and a host pull-up model on the pin.
`timescale 1ns/1ps

module tb_flash_event_interrupt;
  import flash_event_interrupt_pkg::*;
  // ==========================================================
  // Signals
  logic             clk_i, rst_i, hw_reset_n_i, busy_i;
  logic             ecc2_err_i, ecc1_err_i;
  logic             wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [SEL_W-1:0] wb_sel_i;
  logic [DAT_W-1:0] wb_dat_i, wb_dat_o;
  logic             int_n_o, int_oe_n_o, irq_o, pin;
  logic [31:0]      rd;
  logic [15:0]      c, s;
  logic [1:0]       r, e;
  int               failures, tests_run;

  flash_event_interrupt u_flash_event_interrupt (
    .clk_i(clk_i), .rst_i(rst_i), .hw_reset_n_i(hw_reset_n_i),
    .busy_i(busy_i), .ecc2_err_i(ecc2_err_i), .ecc1_err_i(ecc1_err_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .int_n_o(int_n_o),
    .int_oe_n_o(int_oe_n_o), .irq_o(irq_o));
  int_pin_host u_int_pin_host (
    .int_n_i(int_n_o), .int_oe_n_i(int_oe_n_o), .pin_o(pin));

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    failures++;
    print_verdict();
  end

  // ==========================================================
  // Helpers
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) failures++;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    check(rd, x);
  endtask
  task automatic pulse(input logic e2, input logic e1);
    @(posedge clk_i);
    ecc2_err_i <= e2;
    ecc1_err_i <= e1;
    @(posedge clk_i);
    ecc2_err_i <= 1'b0;
    ecc1_err_i <= 1'b0;
    tick(4);
  endtask
  function automatic logic exp_pin(logic [15:0] cf, logic [15:0] st);
    return !(!cf[15] && |(~st & ~cf & EVENT_MASK));
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    {rst_i, hw_reset_n_i, busy_i, ecc2_err_i, ecc1_err_i} = 5'b11000;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    failures = 0;
    tests_run = 0;
    void'($urandom(32'hBD0915D7));
    tick(16);
    rst_i <= 1'b0;
    rd_chk(OFS_CONFIG, 32'h0000FFFF);
    rd_chk(OFS_STATUS, 32'h0000FFFB);
    check(pin, 1'b1);
    rd_chk(4'h2, 32'h0);
    $display("test reset done");
    wr(OFS_CONFIG, 32'h00007FFE);
    pulse(1'b0, 1'b1);
    rd_chk(OFS_STATUS, 32'h0000FFFA);
    check(pin, exp_pin(16'h7FFE, 16'hFFFA));
    wr(OFS_STATUS, 32'h00000001);
    tick(3);
    check(pin, 1'b1);
    rd_chk(OFS_STATUS, 32'h0000FFFB);
    wr(OFS_CONFIG, 32'h00007FFC);
    pulse(1'b1, 1'b1);
    wr(OFS_STATUS, 32'h00000001);
    tick(3);
    check(pin, 1'b0);
    rd_chk(OFS_STATUS, 32'h0000FFF9);
    wr(OFS_STATUS, 32'h00000002);
    tick(3);
    check(pin, 1'b1);
    wr(OFS_CONFIG, 32'h00007FFD);
    pulse(1'b0, 1'b1);
    rd_chk(OFS_STATUS, 32'h0000FFFB);
    check(pin, 1'b1);
    $display("test ecc channels done");
    wr(OFS_CONFIG, 32'h00007FEF);
    @(posedge clk_i);
    busy_i <= 1'b1;
    tick(2);
    busy_i <= 1'b0;
    tick(4);
    rd_chk(OFS_STATUS, 32'h0000FFEB);
    check(pin, 1'b0);
    wr(OFS_CONFIG, 32'h00007FFF);
    tick(3);
    check(pin, 1'b1);
    rd_chk(OFS_STATUS, 32'h0000FFFB);
    $display("test ready done");
    wr(OFS_CONFIG, 32'h00007FFE);
    pulse(1'b0, 1'b1);
    check(pin, 1'b0);
    wr(OFS_CONFIG, 32'h0000FFFE);
    tick(3);
    check(pin, 1'b1);
    rd_chk(OFS_STATUS, 32'h0000FFFF);
    pulse(1'b0, 1'b1);
    check(pin, 1'b1);
    rd_chk(OFS_STATUS, 32'h0000FFFE);
    $display("test output enable done");
    for (int i = 0; i < 6; i++) begin
      r = 2'($urandom());
      e = 2'($urandom());
      c = 16'h7FFC | {14'h0, r};
      s = 16'hFFFF & ~{14'h0, e & ~r};
      wr(OFS_CONFIG, 32'h0000FFFF);
      wr(OFS_CONFIG, {16'h0, c});
      pulse(e[1], e[0]);
      rd_chk(OFS_STATUS, {16'h0, s});
      check(pin, exp_pin(c, s));
    end
    $display("test random done");
    wr(OFS_SYS_STAT, 32'h00000017);
    wr(OFS_SYS_MASK, 32'h00000001);
    rd_chk(OFS_SYS_MASK, 32'h00000001);
    tick(2);
    check(irq_o, 1'b0);
    pulse(1'b0, 1'b1);
    check(irq_o, 1'b1);
    wr(OFS_SYS_MASK, 32'h0);
    tick(2);
    check(irq_o, 1'b0);
    wr(OFS_SYS_MASK, 32'h00000001);
    tick(2);
    check(irq_o, 1'b1);
    wr(OFS_SYS_STAT, 32'h00000001);
    tick(2);
    check(irq_o, 1'b0);
    $display("test system irq done");
    wr(OFS_CONFIG, 32'h00007FFC);
    pulse(1'b0, 1'b1);
    @(posedge clk_i);
    hw_reset_n_i <= 1'b0;
    tick(6);
    hw_reset_n_i <= 1'b1;
    tick(6);
    check(pin, 1'b1);
    rd_chk(OFS_CONFIG, 32'h0000FFFF);
    rd_chk(OFS_STATUS, 32'h0000FFFF);
    $display("test pin reset done");
    print_verdict();
  end
endmodule // tb_flash_event_interrupt
